// *** src/sdc_defines.svh ***
// Notes on behaviour
// - Second select with enable uses alternate divide
// - Otherwise the normal clock divide governs
// - Select tap is signed, added to trim
// - Clock tap is signed, added to trim
// - Receive mask bit picks local receive DMA
// - Transmit mask bit picks local transmit DMA
// - Mask bit n steers descriptor n
// - Sixteen descriptor slots share one layout
// - Local receive field value picks channel
// - Local transmit field value picks channel
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH

// Register byte offsets
`define SDC_OFF_CTRL    12'h000
`define SDC_OFF_STAT    12'h004
`define SDC_OFF_DESC0   12'h030
`define SDC_OFF_DESCN   12'h06C
`define SDC_OFF_ALT     12'h0C0
`define SDC_OFF_TAP     12'h0D4
`define SDC_OFF_RXSEL   12'h100
`define SDC_OFF_TXSEL   12'h104

// Control register fields
`define SDC_CTRL_DIV_HI 31
`define SDC_CTRL_DIV_LO 16
`define SDC_CTRL_CS_HI  1
`define SDC_CTRL_CS_LO  0

// Alternate divide register fields
`define SDC_ALT_DIV_HI  31
`define SDC_ALT_DIV_LO  16
`define SDC_ALT_EN_BIT  0

// Tap trim register fields
`define SDC_TAP_CTL_HI  15
`define SDC_TAP_CTL_LO  8
`define SDC_TAP_SCK_HI  7
`define SDC_TAP_SCK_LO  0

// Descriptor DMA fields
`define SDC_DESC_RX_HI  8
`define SDC_DESC_RX_LO  7
`define SDC_DESC_TX_HI  5
`define SDC_DESC_TX_LO  4

// Select code of the second chip select
`define SDC_SECOND_CS   2'h1

// Reset value of every register word
`define SDC_RST_WORD    32'h0000_0000

`endif

// *** src/sdc_pkg.sv ***
package sdc_pkg;

  // One-hot DMA routing of a descriptor
  typedef enum logic [2:0] {
    SDC_DMA_NONE    = 3'b001,
    SDC_DMA_CENTRAL = 3'b010,
    SDC_DMA_LOCAL   = 3'b100
  } sdc_route_t;

  // Whole state of the top module
  typedef struct packed {
    logic [15:0]       norm_div;
    logic [1:0]        cs;
    logic [15:0]       alt_div;
    logic              alt_en;
    logic [7:0]        ctl_tap;
    logic [7:0]        sck_tap;
    logic [15:0]       rx_sel;
    logic [15:0]       tx_sel;
    logic [15:0][31:0] desc;
    logic [31:0]       prdata;
    logic [15:0]       eff_div;
    logic              alt_act;
    logic [7:0]        ctl_dly;
    logic [7:0]        sck_dly;
    sdc_route_t        rx_rt;
    logic [1:0]        rx_ch;
    logic [1:0]        rx_sz;
    sdc_route_t        tx_rt;
    logic [1:0]        tx_ch;
    logic [1:0]        tx_sz;
    logic [31:0]       cur_word;
  } sdc_state_t;

  // State of the clock divider
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } sdc_div_state_t;

  // Unsigned trim plus signed tap, clamped to 0..255
  function automatic logic [7:0] sdc_trim_add(input logic [7:0] auto_v,
                                              input logic [7:0] tap);
    logic [9:0] s;
    s = {2'b00, auto_v} + {{2{tap[7]}}, tap};
    if (s[9])
      return 8'h00;
    else if (s[8])
      return 8'hFF;
    else
      return s[7:0];
  endfunction

endpackage

// *** src/sdc_clk_div.sv ***
`timescale 1ns/100ps
module sdc_clk_div import sdc_pkg::*; #(
  parameter int W = 16
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         run,
  input  wire logic [W-1:0] div,
  output logic              tick
);

  sdc_div_state_t q;  // Registered state
  sdc_div_state_t d;  // Next state
  logic [W-1:0]   top; // Last count of a period

  // Count system clocks; a divide of zero spans a full wrap
  always_comb begin
    d      = q;
    top    = div - {{(W-1){1'b0}}, 1'b1};
    d.tick = 1'b0;
    if (!run) begin
      // Idle: restart the period
      d.cnt = '0;
    end else if (q.cnt >= top) begin
      // Period done: one tick; at or above, so a divide cut mid-period never wraps
      d.cnt  = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      q <= '0;
    else
      q <= d;
  end

  assign tick = q.tick;

endmodule

// *** src/sdc_dma_route.sv ***
`timescale 1ns/100ps
module sdc_dma_route import sdc_pkg::*; (
  input  wire logic [1:0] field,
  input  wire logic       local_sel,
  output sdc_route_t      route,
  output logic [1:0]      local_chan,
  output logic [1:0]      central_size
);

  // Pick no DMA, local channel or central controller
  always_comb begin
    route        = SDC_DMA_NONE;
    local_chan   = 2'h0;
    central_size = 2'h0;
    if (field == 2'h0) begin
      // Zero field: DMA off
      route = SDC_DMA_NONE;
    end else if (local_sel) begin
      // Field value names the local channel
      route      = SDC_DMA_LOCAL;
      local_chan = field;
    end else begin
      // Field value is the central access size
      route        = SDC_DMA_CENTRAL;
      central_size = field;
    end
  end

endmodule

// *** src/sdc_top.sv ***
`timescale 1ns/100ps
`include "sdc_defines.svh"
module sdc_top import sdc_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  cur_desc,
  input  wire logic        xfer_run,
  input  wire logic [7:0]  auto_ctl_trim,
  input  wire logic [7:0]  auto_sck_trim,
  output logic             sck_tick,
  output logic [15:0]      eff_div,
  output logic             alt_active,
  output logic [1:0]       chip_sel,
  output logic [7:0]       ctl_delay,
  output logic [7:0]       sck_delay,
  output logic [31:0]      desc_word,
  output sdc_route_t       rx_route,
  output logic [1:0]       rx_local_chan,
  output logic [1:0]       rx_central_size,
  output sdc_route_t       tx_route,
  output logic [1:0]       tx_local_chan,
  output logic [1:0]       tx_central_size
);

  sdc_state_t  q;          // Registered state
  sdc_state_t  d;          // Next state
  logic [31:0] rd_val;     // Read mux result
  logic        acc_wr;     // Write access phase
  logic        acc_hit;    // Access hits a register
  logic        use_alt;    // Alternate divide chosen
  logic [31:0] sel_word;   // Descriptor in use now
  sdc_route_t  rx_rt_w;    // Receive routing
  logic [1:0]  rx_ch_w;    // Receive local channel
  logic [1:0]  rx_sz_w;    // Receive central size
  sdc_route_t  tx_rt_w;    // Transmit routing
  logic [1:0]  tx_ch_w;    // Transmit local channel
  logic [1:0]  tx_sz_w;    // Transmit central size

  // Address lies in the descriptor window
  function automatic logic is_desc(input logic [11:0] a);
    return (a >= `SDC_OFF_DESC0) && (a <= `SDC_OFF_DESCN) && (a[1:0] == 2'h0);
  endfunction

  // Descriptor slot addressed
  function automatic logic [3:0] desc_idx(input logic [11:0] a);
    logic [11:0] t;
    t = a - `SDC_OFF_DESC0;
    return t[5:2];
  endfunction

  // Address maps to any register
  function automatic logic is_mapped(input logic [11:0] a);
    return is_desc(a) || (a == `SDC_OFF_CTRL) || (a == `SDC_OFF_STAT) ||
           (a == `SDC_OFF_ALT) || (a == `SDC_OFF_TAP) ||
           (a == `SDC_OFF_RXSEL) || (a == `SDC_OFF_TXSEL);
  endfunction

  // Descriptor receive routing for the slot in use
  sdc_dma_route u_rx_route (
    .field        (sel_word[`SDC_DESC_RX_HI:`SDC_DESC_RX_LO]),
    .local_sel    (q.rx_sel[cur_desc]),
    .route        (rx_rt_w),
    .local_chan   (rx_ch_w),
    .central_size (rx_sz_w)
  );

  // Descriptor transmit routing for the slot in use
  sdc_dma_route u_tx_route (
    .field        (sel_word[`SDC_DESC_TX_HI:`SDC_DESC_TX_LO]),
    .local_sel    (q.tx_sel[cur_desc]),
    .route        (tx_rt_w),
    .local_chan   (tx_ch_w),
    .central_size (tx_sz_w)
  );

  // Serial clock pacing from the chosen divide
  sdc_clk_div #(
    .W (16)
  ) u_clk_div (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (xfer_run),
    .div     (q.eff_div),
    .tick    (sck_tick)
  );

  // Slot selected by the transfer engine
  assign sel_word = q.desc[cur_desc];

  // Access decode
  assign acc_hit = is_mapped(paddr);
  assign acc_wr  = psel && penable && pwrite && acc_hit;
  assign use_alt = q.alt_en && (q.cs == `SDC_SECOND_CS);

  // Read mux; reserved bits stay zero
  always_comb begin
    rd_val = `SDC_RST_WORD;
    if (is_desc(paddr)) begin
      // Any of the sixteen slots
      rd_val = q.desc[desc_idx(paddr)];
    end else begin
      case (paddr)
        `SDC_OFF_CTRL: begin
          rd_val[`SDC_CTRL_DIV_HI:`SDC_CTRL_DIV_LO] = q.norm_div;
          rd_val[`SDC_CTRL_CS_HI:`SDC_CTRL_CS_LO]   = q.cs;
        end
        `SDC_OFF_STAT: begin
          // Live effective divide and delays
          rd_val = {q.eff_div, q.ctl_dly, q.sck_dly};
        end
        `SDC_OFF_ALT: begin
          rd_val[`SDC_ALT_DIV_HI:`SDC_ALT_DIV_LO] = q.alt_div;
          rd_val[`SDC_ALT_EN_BIT]                 = q.alt_en;
        end
        `SDC_OFF_TAP: begin
          rd_val[`SDC_TAP_CTL_HI:`SDC_TAP_CTL_LO] = q.ctl_tap;
          rd_val[`SDC_TAP_SCK_HI:`SDC_TAP_SCK_LO] = q.sck_tap;
        end
        `SDC_OFF_RXSEL: begin
          rd_val[15:0] = q.rx_sel;
        end
        `SDC_OFF_TXSEL: begin
          rd_val[15:0] = q.tx_sel;
        end
        default: begin
          // Unmapped reads return zero
          rd_val = `SDC_RST_WORD;
        end
      endcase
    end
  end

  // Next state: register writes and derived outputs
  always_comb begin
    d = q;
    // Capture read data in the setup phase
    if (psel && !penable) begin
      d.prdata = rd_val;
    end
    // Writes land in the access phase; reserved bits dropped
    if (acc_wr) begin
      if (is_desc(paddr)) begin
        d.desc[desc_idx(paddr)] = pwdata;
      end else begin
        case (paddr)
          `SDC_OFF_CTRL: begin
            d.norm_div = pwdata[`SDC_CTRL_DIV_HI:`SDC_CTRL_DIV_LO];
            d.cs       = pwdata[`SDC_CTRL_CS_HI:`SDC_CTRL_CS_LO];
          end
          `SDC_OFF_ALT: begin
            d.alt_div = pwdata[`SDC_ALT_DIV_HI:`SDC_ALT_DIV_LO];
            d.alt_en  = pwdata[`SDC_ALT_EN_BIT];
          end
          `SDC_OFF_TAP: begin
            d.ctl_tap = pwdata[`SDC_TAP_CTL_HI:`SDC_TAP_CTL_LO];
            d.sck_tap = pwdata[`SDC_TAP_SCK_HI:`SDC_TAP_SCK_LO];
          end
          `SDC_OFF_RXSEL: begin
            d.rx_sel = pwdata[15:0];
          end
          `SDC_OFF_TXSEL: begin
            d.tx_sel = pwdata[15:0];
          end
          default: begin
            // Status is read only
            d.prdata = q.prdata;
          end
        endcase
      end
    end
    // Divide selection
    d.alt_act = use_alt;
    d.eff_div = use_alt ? q.alt_div : q.norm_div;
    // Final delays from trim and signed tap
    d.ctl_dly = sdc_trim_add(auto_ctl_trim, q.ctl_tap);
    d.sck_dly = sdc_trim_add(auto_sck_trim, q.sck_tap);
    // DMA routing of the slot in use
    d.rx_rt    = rx_rt_w;
    d.rx_ch    = rx_ch_w;
    d.rx_sz    = rx_sz_w;
    d.tx_rt    = tx_rt_w;
    d.tx_ch    = tx_ch_w;
    d.tx_sz    = tx_sz_w;
    d.cur_word = sel_word;
  end

  // State register; all cleared at reset except rx_rt and tx_rt, which load SDC_DMA_NONE
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q       <= '0;
      q.rx_rt <= SDC_DMA_NONE;
      q.tx_rt <= SDC_DMA_NONE;
    end else begin
      q <= d;
    end
  end

  // Bus answers: no wait states, error on unmapped
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !acc_hit;
  assign prdata  = q.prdata;

  // Registered outputs
  assign eff_div         = q.eff_div;
  assign alt_active      = q.alt_act;
  assign chip_sel        = q.cs;
  assign ctl_delay       = q.ctl_dly;
  assign sck_delay       = q.sck_dly;
  assign desc_word       = q.cur_word;
  assign rx_route        = q.rx_rt;
  assign rx_local_chan   = q.rx_ch;
  assign rx_central_size = q.rx_sz;
  assign tx_route        = q.tx_rt;
  assign tx_local_chan   = q.tx_ch;
  assign tx_central_size = q.tx_sz;

  // Checks on the design's own outputs
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  alt_div_sel_a: assert property (
    use_alt |=> (eff_div == $past(q.alt_div)) && alt_active)
    else $error("alternate divide not applied");

  norm_div_sel_a: assert property (
    !use_alt |=> (eff_div == $past(q.norm_div)) && !alt_active)
    else $error("normal divide not applied");

  ctl_trim_a: assert property (
    $past(presetn) |-> ctl_delay == sdc_trim_add($past(auto_ctl_trim), $past(q.ctl_tap)))
    else $error("select delay mismatch");

  sck_trim_a: assert property (
    $past(presetn) |-> sck_delay == sdc_trim_add($past(auto_sck_trim), $past(q.sck_tap)))
    else $error("clock delay mismatch");

  rx_local_a: assert property (
    (sel_word[8:7] != 2'h0) && q.rx_sel[cur_desc]
    |=> rx_route == SDC_DMA_LOCAL && rx_local_chan == $past(sel_word[8:7]))
    else $error("local receive DMA not chosen");

  tx_central_a: assert property (
    (sel_word[5:4] != 2'h0) && !q.tx_sel[cur_desc]
    |=> tx_route == SDC_DMA_CENTRAL && tx_local_chan == 2'h0)
    else $error("central transmit DMA not chosen");

  tx_local_a: assert property (
    (sel_word[5:4] != 2'h0) && q.tx_sel[cur_desc]
    |=> tx_route == SDC_DMA_LOCAL && tx_local_chan == $past(sel_word[5:4]))
    else $error("local transmit channel wrong");

  rx_off_a: assert property (
    sel_word[8:7] == 2'h0 |=> rx_route == SDC_DMA_NONE && rx_local_chan == 2'h0)
    else $error("receive DMA not disabled");

  desc_store_a: assert property (
    psel && penable && pwrite && is_desc(paddr)
    |=> q.desc[$past(desc_idx(paddr))] == $past(pwdata))
    else $error("descriptor slot not written");

  rsvd_read_a: assert property (
    psel && penable && !pwrite && (paddr == `SDC_OFF_ALT)
    |-> prdata[15:1] == 15'h0000)
    else $error("reserved bits read nonzero");

  unmapped_err_a: assert property (
    psel && penable && !is_mapped(paddr) |-> pslverr)
    else $error("unmapped access not flagged");

  rx_central_a: assert property (
    (sel_word[8:7] != 2'h0) && !q.rx_sel[cur_desc]
    |=> rx_route == SDC_DMA_CENTRAL && rx_central_size == $past(sel_word[8:7]))
    else $error("central receive DMA not chosen");

  tx_off_a: assert property (
    sel_word[5:4] == 2'h0 |=> tx_route == SDC_DMA_NONE && tx_local_chan == 2'h0)
    else $error("transmit DMA not disabled");

  sck_idle_a: assert property (
    !xfer_run |=> !sck_tick)
    else $error("serial clock ticks while idle");

  sel_out_a: assert property (
    psel && penable && pwrite && (paddr == `SDC_OFF_CTRL)
    |=> chip_sel == $past(pwdata[`SDC_CTRL_CS_HI:`SDC_CTRL_CS_LO]))
    else $error("chip select not taken");

  rst_clear_a: assert property (disable iff (1'b0)
    !presetn |-> (q.alt_en == 1'b0) && (q.rx_sel == 16'h0000) &&
                 (q.tx_sel == 16'h0000) && (eff_div == 16'h0000))
    else $error("fields not cleared in reset");

  alt_used_c:   cover property (use_alt ##1 alt_active);
  rx_local_c:   cover property (rx_route == SDC_DMA_LOCAL);
  tx_central_c: cover property (tx_route == SDC_DMA_CENTRAL);
  tx_local_c:   cover property (tx_route == SDC_DMA_LOCAL);
  bus_err_c:    cover property (pslverr);

endmodule

// *** verif/sdc_slave_model.sv ***
`timescale 1ns/100ps
// Far-side serial device: times the serial clock it receives
module sdc_slave_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        sck_tick,
  output logic      [15:0] period
);
  logic [15:0] cnt_q; // Cycles since the last tick

  // Latch the gap between two ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 16'h0000;
      period <= 16'h0000;
    end else if (sck_tick) begin
      cnt_q  <= 16'h0001;
      period <= cnt_q;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule

// *** verif/sdc_top_tb.sv ***
`timescale 1ns/100ps
`include "sdc_defines.svh"
module sdc_top_tb;
  import sdc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite; // Bus controls
  logic [11:0] paddr;                               // Byte address
  logic [31:0] pwdata, prdata, desc_word;           // Bus and descriptor words
  logic        pready, pslverr, sck_tick, alt_active, xfer_run;
  logic [3:0]  cur_desc;                            // Descriptor in use
  logic [7:0]  auto_ctl_trim, auto_sck_trim, ctl_delay, sck_delay;
  logic [15:0] eff_div, period;                     // Divide and measured gap
  logic [1:0]  chip_sel, rx_local_chan, rx_central_size, tx_local_chan, tx_central_size;
  sdc_route_t  rx_route, tx_route;                  // Routing outputs
  int          n_errors, num_checks, cyc;           // Counters
  logic [31:0] rd;                                  // Last read data
  logic        er;                                  // Last error flag
  logic [11:0] offs [4] = '{`SDC_OFF_ALT, `SDC_OFF_TAP, `SDC_OFF_RXSEL, `SDC_OFF_TXSEL};
  logic [31:0] msk [4]  = '{32'hFFFF_0001, 32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_FFFF};

  sdc_top dut (
    .pclk            (pclk),
    .presetn         (presetn),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .cur_desc        (cur_desc),
    .xfer_run        (xfer_run),
    .auto_ctl_trim   (auto_ctl_trim),
    .auto_sck_trim   (auto_sck_trim),
    .sck_tick        (sck_tick),
    .eff_div         (eff_div),
    .alt_active      (alt_active),
    .chip_sel        (chip_sel),
    .ctl_delay       (ctl_delay),
    .sck_delay       (sck_delay),
    .desc_word       (desc_word),
    .rx_route        (rx_route),
    .rx_local_chan   (rx_local_chan),
    .rx_central_size (rx_central_size),
    .tx_route        (tx_route),
    .tx_local_chan   (tx_local_chan),
    .tx_central_size (tx_central_size)
  );
  sdc_slave_model slv (.pclk(pclk), .presetn(presetn), .sck_tick(sck_tick), .period(period));

  // Free-running clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus transfer, waits for pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read and compare data and error
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
    chk({31'h0, er}, {31'h0, ee});
  endtask

  // Divide choice and measured tick gap
  task automatic div_chk(input logic [15:0] d, input logic a, input logic [1:0] cs);
    repeat (40) @(posedge pclk);
    chk({30'h0, chip_sel}, {30'h0, cs});
    chk({16'h0, eff_div}, {16'h0, d});
    chk({31'h0, alt_active}, {31'h0, a});
    chk({16'h0, period}, {16'h0, d});
  endtask

  // Trims plus taps against expected delays
  task automatic tap_chk(input logic [7:0] au, input logic [15:0] t, input logic [15:0] e);
    auto_ctl_trim <= au;
    auto_sck_trim <= au;
    apb(1'b1, `SDC_OFF_TAP, {16'h0, t});
    repeat (3) @(posedge pclk);
    chk({16'h0, ctl_delay, sck_delay}, {16'h0, e});
  endtask

  // Descriptor word with a marker and both DMA fields
  function automatic logic [31:0] dw(input logic [3:0] n);
    return {12'hA5A, n, 7'h00, n[1:0], 1'b0, n[3:2], 4'h0};
  endfunction

  // Expected route of one field under one mask bit
  task automatic rt_chk(input sdc_route_t r, input logic [1:0] c, input logic [1:0] s,
                        input logic [1:0] f, input logic m);
    chk({29'h0, r}, {29'h0, (f == 2'h0) ? SDC_DMA_NONE : m ? SDC_DMA_LOCAL : SDC_DMA_CENTRAL});
    chk({28'h0, c, s}, {28'h0, m ? f : 2'h0, m ? 2'h0 : f});
  endtask

  // Verdict and stop
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, xfer_run} = 5'h00;
    {paddr, pwdata, cur_desc, auto_ctl_trim, auto_sck_trim} = 64'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({26'h0, rx_route, tx_route}, {26'h0, SDC_DMA_NONE, SDC_DMA_NONE});
    for (int i = 0; i < 4; i++) begin
      rdc(offs[i], 32'h0, 1'b0);
      apb(1'b1, offs[i], 32'hFFFF_FFFF);
      rdc(offs[i], msk[i], 1'b0);
    end
    rdc(12'h200, 32'h0, 1'b1);
    apb(1'b1, `SDC_OFF_ALT, 32'h0003_0000);
    apb(1'b1, `SDC_OFF_CTRL, 32'h0005_0001);
    xfer_run <= 1'b1;
    div_chk(16'h0005, 1'b0, 2'h1);
    apb(1'b1, `SDC_OFF_ALT, 32'h0003_0001);
    div_chk(16'h0003, 1'b1, 2'h1);
    apb(1'b1, `SDC_OFF_CTRL, 32'h0005_0002);
    div_chk(16'h0005, 1'b0, 2'h2);
    tap_chk(8'h10, 16'hFE05, 16'h0E15);
    tap_chk(8'hF0, 16'h7F80, 16'hFF70);
    tap_chk(8'h10, 16'h80F0, 16'h0000);
    apb(1'b1, `SDC_OFF_RXSEL, 32'h0000_A5C3);
    apb(1'b1, `SDC_OFF_TXSEL, 32'h0000_3C5A);
    for (int n = 0; n < 16; n++)
      apb(1'b1, `SDC_OFF_DESC0 + 12'(4 * n), dw(4'(n)));
    for (int n = 0; n < 16; n++) begin
      cur_desc <= 4'(n);
      repeat (3) @(posedge pclk);
      chk(desc_word, dw(4'(n)));
      rt_chk(rx_route, rx_local_chan, rx_central_size, 2'(n), 1'(16'hA5C3 >> n));
      rt_chk(tx_route, tx_local_chan, tx_central_size, 2'(n >> 2), 1'(16'h3C5A >> n));
    end
    // Reset in mid-run clears the configured fields again
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({16'h0, eff_div}, 32'h0);
    chk({31'h0, alt_active}, 32'h0);
    for (int i = 0; i < 4; i++)
      rdc(offs[i], 32'h0, 1'b0);
    end_of_test();
  end
endmodule
